// ---- adc_host.sv ----
`timescale 1ns/10ps
module adc_host #(
   parameter int CLK_HALF = adc_pkg::CONV_CLK_HALF
) (
   input wire logic pclk, // Clock
   input wire logic presetn, // Async reset, low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   output logic irq, // Interrupt, high
   adc_bus_if.host bus // Converter pins
);
   typedef enum logic [2:0] {H_IDLE, H_WSET, H_WLOW, H_WREL, H_RLOW, H_RHI,
      H_RREL} hstate_type;

   hstate_type st_r;
   logic [15:0] cnt_r;
   logic [15:0] gap_r;
   logic [15:0] need_r;
   logic wake_r;
   logic [7:0] ctrl_r;
   logic [1:0] pins_r;
   logic [1:0] mask_r;
   logic [1:0] status_r;
   logic [11:0] result_r;
   logic [31:0] prdata_r;
   logic done_s;
   logic done_q;
   logic [7:0] data_s;
   logic access;
   logic mapped;
   logic wr_cmd;
   logic rd_cmd;
   logic ev_done;
   logic ev_read;
   logic [7:0] div_r;
   logic conv_clk_r;
   logic cs_n_r;
   logic wr_n_r;
   logic rd_n_r;
   logic result_byte_select_r;
   logic oe_n_r;

   pin_sync #(.W(9), .RST(9'h100)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d({bus.done_n, bus.data}),
      .q({done_s, data_s})
   );

   // APB decode; zero wait states, data prepared in setup
   assign access = psel && penable;
   assign mapped = paddr == adc_pkg::REG_CTRL || paddr == adc_pkg::REG_READ ||
      paddr == adc_pkg::REG_RESULT || paddr == adc_pkg::REG_STATUS ||
      paddr == adc_pkg::REG_MASK || paddr == adc_pkg::REG_PINS;
   assign pready = 1'b1;
   assign pslverr = access && !mapped;
   assign prdata = prdata_r;
   // Commands while a pin sequence runs are dropped
   assign wr_cmd = access && pwrite && paddr == adc_pkg::REG_CTRL &&
      st_r == H_IDLE;
   assign rd_cmd = access && pwrite && paddr == adc_pkg::REG_READ &&
      st_r == H_IDLE;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_r <= 32'h0;
      else if (psel && !penable && !pwrite)
         unique case (paddr)
            adc_pkg::REG_CTRL: prdata_r <= {24'h0, ctrl_r};
            adc_pkg::REG_RESULT: prdata_r <= {20'h0, result_r};
            adc_pkg::REG_STATUS:
               prdata_r <= {29'h0, st_r != H_IDLE, status_r};
            adc_pkg::REG_MASK: prdata_r <= {30'h0, mask_r};
            adc_pkg::REG_PINS: prdata_r <= {30'h0, pins_r};
            default: prdata_r <= 32'h0;
         endcase
   end

   // Writable registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_r <= adc_pkg::CTRL_RST;
         pins_r <= adc_pkg::PINS_RST;
         mask_r <= adc_pkg::MASK_RST;
      end
      else if (access && pwrite)
      begin
         if (wr_cmd)
            ctrl_r <= pwdata[7:0];
         if (paddr == adc_pkg::REG_PINS)
            pins_r <= pwdata[1:0];
         if (paddr == adc_pkg::REG_MASK)
            mask_r <= pwdata[1:0];
      end
   end

   // Sticky events; an event beats the read that clears
   assign ev_done = !done_s && done_q;
   assign ev_read = st_r == H_RREL && cnt_r == adc_pkg::REL_CYC;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         status_r <= 2'h0;
         done_q <= 1'b1;
      end
      else
      begin
         done_q <= done_s;
         status_r <= (access && !pwrite && paddr == adc_pkg::REG_STATUS ?
            2'h0 : status_r) | {ev_read, ev_done};
      end
   end
   assign irq = |(status_r & mask_r);

   // Conversion clock from a divider, 1 MHz by default
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_r <= 8'h00;
         conv_clk_r <= 1'b0;
      end
      else if (!pins_r[adc_pkg::PIN_CLK_EN])
         div_r <= 8'h00;
      else if (div_r == 8'(CLK_HALF - 1))
      begin
         div_r <= 8'h00;
         conv_clk_r <= !conv_clk_r;
      end
      else
         div_r <= div_r + 8'h01;
   end

   // Wait owed before a write that ends an external acquisition
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gap_r <= 16'h0;
         need_r <= 16'h0;
         wake_r <= 1'b0;
      end
      else
      begin
         if (st_r == H_WREL)
            gap_r <= 16'h0;
         else if (gap_r != 16'hffff)
            gap_r <= gap_r + 16'h1;
         if (!pins_r[adc_pkg::PIN_SHUTDOWN_PIN_N_N])
            wake_r <= 1'b1;
         if (st_r == H_WREL && cnt_r == 16'h0)
         begin
            wake_r <= ctrl_r[adc_pkg::CB_PD_HI];
            need_r <= !ctrl_r[adc_pkg::CB_ACQ] ? 16'h0 :
               (wake_r ? adc_pkg::WAKE_CYC : adc_pkg::ACQ_MIN_CYC);
         end
      end
   end

   // Pin sequencer; select stays high between transfers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r <= H_IDLE;
         cnt_r <= 16'h0;
         cs_n_r <= 1'b1;
         wr_n_r <= 1'b1;
         rd_n_r <= 1'b1;
         result_byte_select_r <= 1'b0;
         oe_n_r <= 1'b1;
         result_r <= 12'h000;
      end
      else
      begin
         cnt_r <= cnt_r + 16'h1;
         unique case (st_r)
            H_IDLE:
            begin
               cnt_r <= 16'h0;
               cs_n_r <= 1'b1;
               if (wr_cmd)
               begin
                  st_r <= H_WSET;
                  cs_n_r <= 1'b0;
                  oe_n_r <= 1'b0;
               end
               else if (rd_cmd)
               begin
                  st_r <= H_RLOW;
                  cs_n_r <= 1'b0;
                  rd_n_r <= 1'b0;
                  result_byte_select_r <= 1'b0;
               end
            end
            H_WSET:
               if (cnt_r >= adc_pkg::SETUP_CYC && gap_r >= need_r)
               begin
                  st_r <= H_WLOW;
                  cnt_r <= 16'h0;
                  wr_n_r <= 1'b0;
               end
            H_WLOW:
               if (cnt_r == adc_pkg::WR_LOW_CYC)
               begin
                  st_r <= H_WREL;
                  cnt_r <= 16'h0;
                  wr_n_r <= 1'b1;
               end
            H_WREL:
               if (cnt_r == adc_pkg::HOLD_CYC)
               begin
                  st_r <= H_IDLE;
                  oe_n_r <= 1'b1;
                  cs_n_r <= 1'b1;
               end
            H_RLOW:
               if (cnt_r == adc_pkg::RD_WAIT_CYC)
               begin
                  st_r <= H_RHI;
                  cnt_r <= 16'h0;
                  result_r[7:0] <= data_s;
                  result_byte_select_r <= 1'b1;
               end
            H_RHI:
               if (cnt_r == adc_pkg::RD_WAIT_CYC)
               begin
                  st_r <= H_RREL;
                  cnt_r <= 16'h0;
                  result_r[11:8] <= data_s[3:0];
                  rd_n_r <= 1'b1;
                  cs_n_r <= 1'b1;
               end
            H_RREL:
               if (cnt_r == adc_pkg::REL_CYC)
                  st_r <= H_IDLE;
            default: st_r <= H_IDLE;
         endcase
      end
   end

   assign bus.cs_n = cs_n_r;
   assign bus.wr_n = wr_n_r;
   assign bus.rd_n = rd_n_r;
   assign bus.result_byte_select = result_byte_select_r;
   assign bus.shutdown_pin_n = pins_r[adc_pkg::PIN_SHUTDOWN_PIN_N_N];
   assign bus.conv_clk = conv_clk_r;
   assign bus.host_dout = ctrl_r;
   assign bus.host_oe_n = oe_n_r;
endmodule : adc_host

// ---- adc_pkg.sv ----
package adc_pkg;
   // Control byte field positions
   localparam int CB_PD_HI = 7;
   localparam int CB_PD_LO = 6;
   localparam int CB_ACQ = 5;
   localparam int CB_RNG = 4;
   localparam int CB_BIP = 3;
   localparam int CB_CH_LSB = 0;
   localparam int CB_CH_W = 3;
   // Power and clock modes
   localparam logic [1:0] PM_EXT_CLK = 2'h0;
   localparam logic [1:0] PM_INT_CLK = 2'h1;
   localparam logic [1:0] PM_STANDBY = 2'h2;
   localparam logic [1:0] PM_FULL = 2'h3;
   localparam logic [7:0] CTRL_RST = 8'h00;
   // Conversion clock counts
   localparam logic [3:0] ACQ_TICKS = 4'h6;
   localparam logic [3:0] CONV_TICKS = 4'hc;
   // Times in ns and derived pclk counts
   localparam int CLK_NS = 10;
   localparam int ACQ_MIN_NS = 3000;
   localparam int WAKE_NS = 5000;
   localparam int WR_LOW_NS = 80;
   localparam int T_DO_NS = 120;
   localparam int T_RH_NS = 70;
   localparam logic [15:0] ACQ_MIN_CYC =
      16'((ACQ_MIN_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] WAKE_CYC = 16'((WAKE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] WR_LOW_CYC =
      16'((WR_LOW_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [15:0] RD_WAIT_CYC = 16'(T_DO_NS / CLK_NS + 4);
   localparam logic [15:0] REL_CYC = 16'(T_RH_NS / CLK_NS);
   localparam logic [15:0] SETUP_CYC = 16'h0002;
   localparam logic [15:0] HOLD_CYC = 16'h0004;
   // Clock dividers (half periods in pclk cycles)
   localparam int INT_OSC_HALF = 32;
   localparam int CONV_CLK_HALF = 50;
   // Host register map
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_READ = 8'h04;
   localparam logic [7:0] REG_RESULT = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   localparam logic [7:0] REG_MASK = 8'h10;
   localparam logic [7:0] REG_PINS = 8'h14;
   localparam int ST_DONE = 0;
   localparam int ST_READ = 1;
   localparam int ST_BUSY = 2;
   localparam int PIN_SHUTDOWN_PIN_N_N = 0;
   localparam int PIN_CLK_EN = 1;
   localparam logic [1:0] PINS_RST = 2'h3;
   localparam logic [1:0] MASK_RST = 2'h0;
endpackage : adc_pkg

// ---- adc_bus_if.sv ----
`timescale 1ns/10ps
interface adc_bus_if;
   logic cs_n;
   logic wr_n;
   logic rd_n;
   logic result_byte_select;
   logic shutdown_pin_n;
   logic conv_clk;
   logic done_n;
   logic [7:0] host_dout;
   logic host_oe_n;
   logic [7:0] dev_dout;
   logic dev_oe_n;
   logic [7:0] data;

   // Shared data lines; an undriven bus reads as pulled high
   assign data = !dev_oe_n ? dev_dout : (!host_oe_n ? host_dout : 8'hff);

   modport dev (input cs_n, wr_n, rd_n, result_byte_select, shutdown_pin_n,
      conv_clk, data, output dev_dout, dev_oe_n, done_n);
   modport host (output cs_n, wr_n, rd_n, result_byte_select,
      shutdown_pin_n, conv_clk, host_dout, host_oe_n, input data, done_n);
endinterface : adc_bus_if

// ---- pin_sync.sv ----
`timescale 1ns/10ps
module pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic pclk, // Clock
   input wire logic presetn, // Async reset, low
   input wire logic [W-1:0] d, // Pin level
   output logic [W-1:0] q // Synchronised level
);
   logic [W-1:0] meta_r;

   // First stage is read only by the second
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_r <= RST;
         q <= RST;
      end
      else
      begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule : pin_sync

// ---- adc_device.sv ----
// Operation
// - Internal acquisition: write latches byte, converts
// - External acquisition: second write starts conversion
// - Read falling edge drives result onto bus
// - Byte select picks upper or lower half
// - Low lines carry bits 0-3 or 8-11
// - Shutdown pin low forces full power-down
// - Host supplies 0.1 to 2 MHz clock
// - Host spaces external acquisition writes 3 us
// - Host allows 5 us after power-down
// - Read low returns completion flag high
// - Read high releases data lines quickly
// - Byte select change switches driven half
// - Completion flag low when result ready
// - Control byte field layout
// - Conversion takes twelve clock cycles
// - Internal acquisition lasts six clock cycles
`timescale 1ns/10ps
module adc_device #(
   parameter int OSC_HALF = adc_pkg::INT_OSC_HALF
) (
   input wire logic pclk, // Clock
   input wire logic presetn, // Async reset, low
   adc_bus_if.dev bus, // Parallel pins
   input wire logic [7:0][11:0] analog_code, // Per-channel sample code
   output logic [1:0] power_mode, // Current power and clock mode
   output logic busy, // Acquiring or converting
   output logic [2:0] channel // Selected channel
);
   typedef enum logic [1:0] {S_IDLE, S_ACQ_INT, S_ACQ_EXT, S_CONV}
      state_type;

   logic cs_s;
   logic wr_s;
   logic rd_s;
   logic result_byte_select_s;
   logic shutdown_pin_n_s;
   logic clk_s;
   logic [7:0] data_s;
   logic wr_q;
   logic rd_q;
   logic clk_q;
   logic wr_rise;
   logic rd_fall;
   logic reading;
   logic full_pd;
   logic tick;
   logic osc_tick;
   logic [7:0] ctrl_r;
   logic clk_int_r;
   logic [7:0] osc_cnt_r;
   state_type state_r;
   logic [3:0] cyc_r;
   logic start_ext;
   logic acq_end;
   logic conv_end;
   logic [11:0] held_r;
   logic [11:0] result_r;
   logic res_bip_r;
   logic done_n_r;
   logic drive_r;
   logic [7:0] dout_r;

   // Pins come from another party: two flops each
   // Reset levels match the idle strobe and clock pins, so no false edge follows reset
   pin_sync #(.W(6), .RST(6'h3c)) u_ctl_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d({bus.cs_n, bus.wr_n, bus.rd_n, bus.result_byte_select,
         bus.shutdown_pin_n, bus.conv_clk}),
      .q({cs_s, wr_s, rd_s, result_byte_select_s, shutdown_pin_n_s, clk_s})
   );
   pin_sync #(.W(8), .RST(8'h00)) u_data_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d(bus.data),
      .q(data_s)
   );

   // Previous synced levels for edge detection
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wr_q <= 1'b1;
         rd_q <= 1'b1;
         clk_q <= 1'b0;
      end
      else
      begin
         wr_q <= wr_s;
         rd_q <= rd_s;
         clk_q <= clk_s;
      end
   end

   // Strobes count only with chip select low
   assign wr_rise = !cs_s && wr_s && !wr_q;
   assign rd_fall = !cs_s && !rd_s && rd_q;
   assign reading = !cs_s && !rd_s;
   assign full_pd = !shutdown_pin_n_s ||
      ctrl_r[adc_pkg::CB_PD_HI:adc_pkg::CB_PD_LO] == adc_pkg::PM_FULL;

   // Control byte; writes ignored while the shutdown pin holds us off
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_r <= adc_pkg::CTRL_RST;
      else if (wr_rise && shutdown_pin_n_s)
         ctrl_r <= data_s;
   end

   // Standby and full power-down leave the clock mode as it was
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         clk_int_r <= 1'b0;
      else if (wr_rise && shutdown_pin_n_s && !data_s[adc_pkg::CB_PD_HI])
         clk_int_r <= data_s[adc_pkg::CB_PD_LO];
   end

   // Internal oscillator stands in for the capacitor-set clock
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         osc_cnt_r <= 8'h00;
      else if (!clk_int_r || osc_tick)
         osc_cnt_r <= 8'h00;
      else
         osc_cnt_r <= osc_cnt_r + 8'h01;
   end
   assign osc_tick = clk_int_r && osc_cnt_r == 8'(2 * OSC_HALF - 1);

   // One tick per conversion-clock period from the chosen source
   assign tick = clk_int_r ? osc_tick : (clk_s && !clk_q);

   // Acquisition and conversion ends
   assign start_ext = wr_rise && shutdown_pin_n_s && state_r == S_ACQ_EXT &&
      !data_s[adc_pkg::CB_PD_HI] && !data_s[adc_pkg::CB_ACQ];
   assign acq_end = state_r == S_ACQ_INT && tick &&
      cyc_r == adc_pkg::ACQ_TICKS - 4'h1;
   assign conv_end = state_r == S_CONV && tick &&
      cyc_r == adc_pkg::CONV_TICKS - 4'h1;

   // Sequencer; a write mid-conversion aborts and restarts acquisition, or goes idle if it sets power-down
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r <= S_IDLE;
         cyc_r <= 4'h0;
      end
      else if (full_pd)
      begin
         state_r <= S_IDLE;
         cyc_r <= 4'h0;
      end
      else if (wr_rise)
      begin
         cyc_r <= 4'h0;
         if (data_s[adc_pkg::CB_PD_HI])
            state_r <= S_IDLE;
         else if (start_ext)
            state_r <= S_CONV;
         else if (data_s[adc_pkg::CB_ACQ])
            state_r <= S_ACQ_EXT;
         else
            state_r <= S_ACQ_INT;
      end
      else if (acq_end)
      begin
         state_r <= S_CONV;
         cyc_r <= 4'h0;
      end
      else if (conv_end)
      begin
         state_r <= S_IDLE;
         cyc_r <= 4'h0;
      end
      else if (tick && (state_r == S_ACQ_INT || state_r == S_CONV))
         cyc_r <= cyc_r + 4'h1;
   end

   // Sample held at the end of acquisition
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         held_r <= 12'h000;
      else if (start_ext)
         held_r <= analog_code[data_s[adc_pkg::CB_CH_LSB +: adc_pkg::CB_CH_W]];
      else if (acq_end)
         held_r <= analog_code[ctrl_r[adc_pkg::CB_CH_LSB +: adc_pkg::CB_CH_W]];
   end

   // Result and its polarity kept together until the next conversion
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         result_r <= 12'h000;
         res_bip_r <= 1'b0;
      end
      else if (conv_end)
      begin
         result_r <= held_r;
         res_bip_r <= ctrl_r[adc_pkg::CB_BIP];
      end
   end

   // Completion flag: a finish in the same cycle as a read wins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         done_n_r <= 1'b1;
      else if (conv_end)
         done_n_r <= 1'b0;
      else if (reading)
         done_n_r <= 1'b1;
   end

   // Drive starts at the read falling edge, ends on read or select high
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         drive_r <= 1'b0;
      else if (!reading)
         drive_r <= 1'b0;
      else if (rd_fall)
         drive_r <= 1'b1;
   end

   // Byte mux follows select every cycle, so a change mid-read shows
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         dout_r <= 8'h00;
      else if (result_byte_select_s)
         dout_r <= {res_bip_r ? {4{result_r[11]}} : 4'h0,
            result_r[11:8]};
      else
         dout_r <= result_r[7:0];
   end

   // Pin outputs; low enable means driving
   assign bus.dev_dout = dout_r;
   assign bus.dev_oe_n = !drive_r;
   assign bus.done_n = done_n_r;

   // User-side status
   assign power_mode = full_pd ? adc_pkg::PM_FULL :
      ctrl_r[adc_pkg::CB_PD_HI:adc_pkg::CB_PD_LO];
   assign busy = state_r != S_IDLE;
   assign channel = ctrl_r[adc_pkg::CB_CH_LSB +: adc_pkg::CB_CH_W];
endmodule : adc_device

// ---- adc_bus_properties.sv ----
`timescale 1ns/10ps
module adc_bus_properties (
   input wire logic pclk, // Clock
   input wire logic presetn, // Async reset, low
   input wire logic cs_n, // Chip select
   input wire logic wr_n, // Write strobe
   input wire logic rd_n, // Read strobe
   input wire logic result_byte_select, // Upper half select
   input wire logic shutdown_pin_n, // Shutdown pin
   input wire logic done_n, // Completion flag
   input wire logic host_oe_n, // Host drive enable
   input wire logic [7:0] dev_dout, // Device data
   input wire logic dev_oe_n // Device drive enable
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Pin timing relations, figures from the hand-over latencies
   cs_idle_hiz_a: assert property (cs_n [*5] |-> dev_oe_n)
      else $error("device drives bus while deselected");
   rd_drive_a: assert property (
      $fell(rd_n) && !cs_n |-> ##[1:4] !dev_oe_n)
      else $error("read strobe did not enable device data");
   rd_release_a: assert property ($rose(rd_n) |-> ##[1:4] dev_oe_n)
      else $error("data lines not released after read");
   done_clear_a: assert property (
      !done_n && $fell(rd_n) && !cs_n |-> ##[1:4] done_n)
      else $error("completion flag not cleared by read");
   bus_fight_a: assert property (!(!dev_oe_n && !host_oe_n))
      else $error("both ends drive the data lines");
   wr_quiet_a: assert property (!wr_n |-> dev_oe_n)
      else $error("device drives bus during a write");
   upper_fill_a: assert property (
      $rose(result_byte_select) && !rd_n && !cs_n |-> ##4 (!dev_oe_n
      && (dev_dout[7:4] == 4'h0 || dev_dout[7:4] == {4{dev_dout[3]}})))
      else $error("upper half lines not zero or sign copies");
   shutdown_quiet_a: assert property (
      !shutdown_pin_n [*8] |-> !$fell(done_n))
      else $error("conversion completed while shut down");

   // Main traffic seen at least once
   read_seen_c: cover property ($fell(rd_n) && !cs_n);
   done_seen_c: cover property ($fell(done_n));
   upper_seen_c: cover property ($rose(result_byte_select) && !rd_n);
endmodule : adc_bus_properties

// ---- adc_parallel_host_control_test.sv ----
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
   err_count++; $display("unexpected %s exp %h got %h", nm, ex, got); end end
module adc_parallel_host_control_test;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd_data;
   logic [7:0][11:0] analog_code;
   logic [1:0] power_mode;
   logic [2:0] channel;
   logic bus_err;
   logic busy;
   int err_count = 0;
   int checks_done = 0;

   adc_bus_if bus_if ();
   adc_device u_adc_device (.pclk(pclk), .presetn(presetn), .bus(bus_if),
      .analog_code(analog_code), .power_mode(power_mode), .busy(busy),
      .channel(channel));
   adc_host u_adc_host (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .bus(bus_if));
   adc_bus_properties u_adc_bus_properties (.pclk(pclk), .presetn(presetn),
      .cs_n(bus_if.cs_n), .wr_n(bus_if.wr_n), .rd_n(bus_if.rd_n),
      .result_byte_select(bus_if.result_byte_select),
      .shutdown_pin_n(bus_if.shutdown_pin_n), .done_n(bus_if.done_n),
      .host_oe_n(bus_if.host_oe_n), .dev_dout(bus_if.dev_dout),
      .dev_oe_n(bus_if.dev_oe_n));

   // 100 MHz clock
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic stop_test;
      if (err_count == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : stop_test

   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd_data = prdata;
      bus_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Reset values of the pins, mask and status registers and an unmapped access
   task automatic t_reset;
      apb(1'b0, adc_pkg::REG_PINS, 32'h0);
      `CHK("pins", 32'h00000003, rd_data)
      apb(1'b0, adc_pkg::REG_MASK, 32'h0);
      `CHK("mask", 32'h00000000, rd_data)
      apb(1'b0, adc_pkg::REG_STATUS, 32'h0);
      `CHK("status", 32'h00000000, rd_data)
      apb(1'b0, 8'h20, 32'h0);
      `CHK("unmapped err", 1'b1, bus_err)
      `CHK("unmapped data", 32'h00000000, rd_data)
   endtask : t_reset

   // Control writes are dropped while a pin sequence runs, so wait
   task automatic wait_idle;
      int n;
      n = 0;
      rd_data = 32'h4;
      while (rd_data[adc_pkg::ST_BUSY] !== 1'b0 && n < 100)
      begin
         apb(1'b0, adc_pkg::REG_STATUS, 32'h0);
         n++;
      end
      `CHK("host idle", 1'b0, rd_data[adc_pkg::ST_BUSY])
   endtask : wait_idle

   // Full conversion plus two-byte readback for one control byte
   task automatic t_convert(input logic [7:0] ctrl);
      int n;
      apb(1'b1, adc_pkg::REG_MASK, 32'h1);
      wait_idle();
      apb(1'b1, adc_pkg::REG_CTRL, {24'h0, ctrl});
      n = 0;
      while (irq !== 1'b1 && n < 6000)
      begin
         @(posedge pclk);
         n++;
      end
      `CHK("irq raised", 1'b1, irq)
      `CHK("busy after done", 1'b0, busy)
      `CHK("channel", ctrl[2:0], channel)
      apb(1'b0, adc_pkg::REG_STATUS, 32'h0);
      `CHK("done bit", 1'b1, rd_data[adc_pkg::ST_DONE])
      @(posedge pclk);
      `CHK("irq cleared", 1'b0, irq)
      apb(1'b1, adc_pkg::REG_READ, 32'h0);
      n = 0;
      rd_data = 32'h0;
      while (rd_data[adc_pkg::ST_READ] !== 1'b1 && n < 40)
      begin
         apb(1'b0, adc_pkg::REG_STATUS, 32'h0);
         n++;
      end
      apb(1'b0, adc_pkg::REG_RESULT, 32'h0);
      `CHK("result", {20'h0, analog_code[ctrl[2:0]]}, rd_data)
   endtask : t_convert

   // External acquisition: opening write, then closing write
   task automatic t_external;
      apb(1'b1, adc_pkg::REG_CTRL, 32'h00000023);
      t_convert(8'h03);
   endtask : t_external

   // Shutdown pin overrides the control byte and blocks conversions
   task automatic t_shutdown;
      apb(1'b1, adc_pkg::REG_PINS, 32'h2);
      repeat (10) @(posedge pclk);
      `CHK("power mode", adc_pkg::PM_FULL, power_mode)
      apb(1'b1, adc_pkg::REG_CTRL, 32'h00000001);
      repeat (3000) @(posedge pclk);
      `CHK("no irq", 1'b0, irq)
      apb(1'b1, adc_pkg::REG_PINS, 32'h3);
      repeat (10) @(posedge pclk);
      `CHK("mode back", adc_pkg::PM_EXT_CLK, power_mode)
   endtask : t_shutdown

   // Watchdog well beyond the expected run length
   initial
   begin
      repeat (80000) @(posedge pclk);
      err_count++;
      stop_test();
   end

   // Main sequence
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      for (int i = 0; i < 8; i++)
         analog_code[i] = {4'(9 + i), 8'h5a ^ 8'(i)};
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_convert(8'h05);
      t_convert(8'h0a);
      t_convert(8'h47);
      t_external();
      t_shutdown();
      stop_test();
   end
endmodule : adc_parallel_host_control_test
